// ==== tsc_count_div.sv ====
`timescale 1ns/1ps

// Produces a one-cycle count clock enable every DIV mclk cycles
module tsc_count_div
    import tsc_pkg::*;
#(
    parameter int DIV = TSC_COUNT_DIV
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Enable pulse
    output logic tick
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic tick_reg;
    logic wrap;

    assign wrap = (count_reg == LAST);
    assign count_next = wrap ? '0 : count_reg + CW'(1);
    assign tick = tick_reg;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick_reg <= wrap;
        end
    end

endmodule

// ==== tsc_pkg.sv ====
package tsc_pkg;

    // Register byte addresses per unit (word registers on even addresses)
    localparam logic [19:0] TSC_ENABLE_OFS_U0 = 20'h0_F01B0;
    localparam logic [19:0] TSC_START_OFS_U0 = 20'h0_F01B2;
    localparam logic [19:0] TSC_STOP_OFS_U0 = 20'h0_F01B4;
    localparam logic [19:0] TSC_ENABLE_OFS_U1 = 20'h0_F01F0;
    localparam logic [19:0] TSC_START_OFS_U1 = 20'h0_F01F2;
    localparam logic [19:0] TSC_STOP_OFS_U1 = 20'h0_F01F4;
    localparam logic [19:0] TSC_ENABLE_OFS_U2 = 20'h0_F0230;
    localparam logic [19:0] TSC_START_OFS_U2 = 20'h0_F0232;
    localparam logic [19:0] TSC_STOP_OFS_U2 = 20'h0_F0234;

    // Reset values and capture start load value
    localparam logic [15:0] TSC_TRIG_RESET = 16'h0000;
    localparam logic [15:0] TSC_ENABLE_RESET = 16'h0000;
    localparam logic [15:0] TSC_CAPTURE_LOAD = 16'h0000;

    // Field positions
    localparam int TSC_CHAN_FIELD_LSB = 0;
    localparam int TSC_MAX_CHANNELS = 8;

    // Start source codes: software only, timer input pin edge
    localparam logic [2:0] TSC_SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] TSC_SRC_PIN = 3'h1;

    // Count clock divide ratio from mclk
    localparam int TSC_COUNT_DIV = 4;

    typedef enum logic [2:0] {
        TSC_MODE_INTERVAL = 3'b000,
        TSC_MODE_CAPTURE = 3'b010,
        TSC_MODE_EVENT = 3'b011,
        TSC_MODE_ONE_COUNT = 3'b100,
        TSC_MODE_CAP_ONE = 3'b110
    } tsc_mode_type;

    typedef enum logic [1:0] {
        TSC_ST_STOPPED = 2'b00,
        TSC_ST_WAIT_CLK = 2'b01,
        TSC_ST_COUNTING = 2'b11,
        TSC_ST_WAIT_TRIG = 2'b10
    } tsc_state_type;

    typedef enum logic [1:0] {
        TSC_SIZE_WORD = 2'b00,
        TSC_SIZE_BYTE = 2'b01,
        TSC_SIZE_BIT = 2'b10
    } tsc_size_type;

    typedef struct packed {
        logic wr;
        logic rd;
        tsc_size_type size;
        logic [19:0] addr;
        logic [15:0] wdata;
        logic [2:0] bit_idx;
    } tsc_bus_req_type;

    typedef struct packed {
        tsc_mode_type mode_select_field;
        logic start_irq_select;
        logic [2:0] start_source_select;
    } tsc_chan_cfg_type;

endpackage

// ==== tsc_unit.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Start bit write sets channel enable status
// - Start trigger register always reads zero
// - Interval: next count clock loads reload, decrements
// - Interval/capture: start held until count clock
// - Event counter: start write loads reload immediately
// - Event counter ignores external start triggers
// - Event counter holds value while disabled
// - Capture: next count clock loads zero, increments
// - One-count: wait trigger, load reload, count down
// - Capture one-count: wait trigger, load zero, up
// - Pin-sourced trigger lags one count clock
// - Stop bit write clears enable, stops counting
// - Stop bit self-clears once enable is zero
// - Stop register: word, byte, bit writes low
// - Reset clears stop trigger register
// - Start bit self-clears once enable is one
// - Capture code 010, capture one-count 110
// - Stop trigger register always reads zero
module tsc_unit
    import tsc_pkg::*;
#(
    parameter int CHANNELS = TSC_MAX_CHANNELS,
    parameter int UNIT = 0,
    parameter int COUNT_DIV = TSC_COUNT_DIV
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register access
    input wire tsc_bus_req_type bus_req,
    output logic [15:0] rdata,
    // Channel setup
    input wire tsc_chan_cfg_type [CHANNELS-1:0] channel_mode_config,
    input wire logic [CHANNELS-1:0][15:0] reload_data,
    // Detected start triggers per channel
    input wire logic [CHANNELS-1:0] ext_start_trig,
    // Channel state
    output logic [CHANNELS-1:0] chan_enable_status,
    output logic [CHANNELS-1:0][15:0] channel_counter,
    output logic [CHANNELS-1:0] count_start_irq
);

    function automatic logic [19:0] unit_base(input int sel, input int u);
        logic [19:0] r;
        r = TSC_ENABLE_OFS_U0;
        case (u)
            1: r = (sel == 0) ? TSC_ENABLE_OFS_U1 :
                   (sel == 1) ? TSC_START_OFS_U1 : TSC_STOP_OFS_U1;
            2: r = (sel == 0) ? TSC_ENABLE_OFS_U2 :
                   (sel == 1) ? TSC_START_OFS_U2 : TSC_STOP_OFS_U2;
            default: r = (sel == 0) ? TSC_ENABLE_OFS_U0 :
                   (sel == 1) ? TSC_START_OFS_U0 : TSC_STOP_OFS_U0;
        endcase
        return r;
    endfunction

    // Trigger-register write mask for low-byte channel bits
    function automatic logic [CHANNELS-1:0] trig_mask(input tsc_bus_req_type r);
        logic [15:0] bits;
        bits = 16'h0000;
        case (r.size)
            TSC_SIZE_WORD: bits = r.wdata;
            TSC_SIZE_BYTE: bits = {8'h00, r.wdata[7:0]};
            TSC_SIZE_BIT: bits = 16'(r.wdata[0]) << r.bit_idx;
            default: bits = 16'h0000;
        endcase
        return bits[TSC_CHAN_FIELD_LSB +: CHANNELS];
    endfunction

    function automatic logic is_up_mode(input tsc_mode_type m);
        return (m == TSC_MODE_CAPTURE) || (m == TSC_MODE_CAP_ONE);
    endfunction

    function automatic logic is_one_count(input tsc_mode_type m);
        return (m == TSC_MODE_ONE_COUNT) || (m == TSC_MODE_CAP_ONE);
    endfunction

    localparam logic [19:0] ENABLE_ADDR = unit_base(0, UNIT);
    localparam logic [19:0] START_ADDR = unit_base(1, UNIT);
    localparam logic [19:0] STOP_ADDR = unit_base(2, UNIT);

    logic count_tick;

    tsc_count_div #(
        .DIV(COUNT_DIV)
    ) u_div (
        .mclk(mclk),
        .reset(reset),
        .tick(count_tick)
    );

    // Address decode
    wire hit_enable = (bus_req.addr == ENABLE_ADDR);
    wire hit_enable_hi = (bus_req.addr == ENABLE_ADDR + 20'h0_0001);
    wire wr_start = bus_req.wr && (bus_req.addr == START_ADDR);
    wire wr_stop = bus_req.wr && (bus_req.addr == STOP_ADDR);
    wire [CHANNELS-1:0] wmask = trig_mask(bus_req);

    logic [CHANNELS-1:0] start_trig_reg;
    logic [CHANNELS-1:0] start_trig_next;
    logic [CHANNELS-1:0] stop_trig_reg;
    logic [CHANNELS-1:0] stop_trig_next;
    logic [CHANNELS-1:0] enable_reg;
    logic [CHANNELS-1:0] enable_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    // A new write wins over the self-clear in the same cycle
    assign start_trig_next = (start_trig_reg & ~enable_next)
                           | (wr_start ? wmask : '0);
    assign stop_trig_next = (stop_trig_reg & enable_next)
                          | (wr_stop ? wmask : '0);
    // Stop wins over start when both are pending
    assign enable_next = (enable_reg | start_trig_reg) & ~stop_trig_reg;

    // Only the enable register returns data; trigger registers read zero
    assign rdata_next = (!bus_req.rd) ? rdata_reg :
                        hit_enable ? 16'(enable_reg) :
                        hit_enable_hi ? 16'h0000 :
                        16'h0000;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            start_trig_reg <= CHANNELS'(TSC_TRIG_RESET);
            stop_trig_reg <= CHANNELS'(TSC_TRIG_RESET);
            enable_reg <= CHANNELS'(TSC_ENABLE_RESET);
            rdata_reg <= 16'h0000;
        end
        else
        begin
            start_trig_reg <= start_trig_next;
            stop_trig_reg <= stop_trig_next;
            enable_reg <= enable_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign chan_enable_status = enable_reg;

    // Per-channel start control and counter
    tsc_state_type state_reg [CHANNELS];
    tsc_state_type state_next [CHANNELS];
    logic [15:0] cnt_reg [CHANNELS];
    logic [15:0] cnt_next [CHANNELS];
    logic [CHANNELS-1:0] pin_pend_reg;
    logic [CHANNELS-1:0] pin_pend_next;
    logic [CHANNELS-1:0] irq_reg;
    logic [CHANNELS-1:0] irq_next;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : g_chan
            tsc_mode_type mode;
            logic start_evt;
            logic stop_evt;
            logic trig_seen;
            logic from_pin;
            logic up;
            logic [15:0] first_val;
            logic at_end;

            assign mode = channel_mode_config[ch].mode_select_field;
            assign start_evt = start_trig_reg[ch] && !stop_trig_reg[ch];
            assign stop_evt = stop_trig_reg[ch];
            assign from_pin = (channel_mode_config[ch].start_source_select == TSC_SRC_PIN);
            assign up = is_up_mode(mode);
            assign first_val = up ? TSC_CAPTURE_LOAD : reload_data[ch];
            assign at_end = up ? (cnt_reg[ch] == 16'hFFFF) : (cnt_reg[ch] == 16'h0000);
            // External triggers count only in the one-count modes
            assign trig_seen = ext_start_trig[ch] && is_one_count(mode);

            always_comb
            begin
                state_next[ch] = state_reg[ch];
                cnt_next[ch] = cnt_reg[ch];
                pin_pend_next[ch] = pin_pend_reg[ch];
                irq_next[ch] = 1'b0;
                if (stop_evt)
                begin
                    // Counter keeps its value when stopped
                    state_next[ch] = TSC_ST_STOPPED;
                    pin_pend_next[ch] = 1'b0;
                end
                else
                begin
                    case (state_reg[ch])
                        TSC_ST_STOPPED:
                        begin
                            if (start_evt)
                            begin
                                case (mode)
                                    TSC_MODE_EVENT:
                                    begin
                                        cnt_next[ch] = reload_data[ch];
                                        state_next[ch] = TSC_ST_COUNTING;
                                    end
                                    TSC_MODE_ONE_COUNT, TSC_MODE_CAP_ONE:
                                        state_next[ch] = TSC_ST_WAIT_TRIG;
                                    default:
                                        state_next[ch] = TSC_ST_WAIT_CLK;
                                endcase
                            end
                        end
                        TSC_ST_WAIT_CLK:
                        begin
                            // Counter keeps prior value until the count clock
                            if (count_tick)
                            begin
                                cnt_next[ch] = first_val;
                                state_next[ch] = TSC_ST_COUNTING;
                                irq_next[ch] = channel_mode_config[ch].start_irq_select;
                            end
                        end
                        TSC_ST_WAIT_TRIG:
                        begin
                            if (pin_pend_reg[ch] && count_tick)
                            begin
                                pin_pend_next[ch] = 1'b0;
                                state_next[ch] = TSC_ST_WAIT_CLK;
                            end
                            else if (trig_seen && from_pin)
                                pin_pend_next[ch] = 1'b1;
                            else if (trig_seen)
                                state_next[ch] = TSC_ST_WAIT_CLK;
                        end
                        TSC_ST_COUNTING:
                        begin
                            if (mode == TSC_MODE_ONE_COUNT && trig_seen
                                && channel_mode_config[ch].start_irq_select)
                                state_next[ch] = TSC_ST_WAIT_CLK;
                            else if (count_tick)
                            begin
                                if (is_one_count(mode) && at_end)
                                    state_next[ch] = TSC_ST_WAIT_TRIG;
                                else if (!up && at_end)
                                    cnt_next[ch] = reload_data[ch];
                                else if (up)
                                    cnt_next[ch] = cnt_reg[ch] + 16'h0001;
                                else
                                    cnt_next[ch] = cnt_reg[ch] - 16'h0001;
                            end
                        end
                        default:
                            state_next[ch] = TSC_ST_STOPPED;
                    endcase
                end
            end

            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    state_reg[ch] <= TSC_ST_STOPPED;
                    cnt_reg[ch] <= 16'h0000;
                    pin_pend_reg[ch] <= 1'b0;
                    irq_reg[ch] <= 1'b0;
                end
                else
                begin
                    // Disabled event counter simply holds cnt_reg
                    state_reg[ch] <= state_next[ch];
                    cnt_reg[ch] <= cnt_next[ch];
                    pin_pend_reg[ch] <= pin_pend_next[ch];
                    irq_reg[ch] <= irq_next[ch];
                end
            end

            assign channel_counter[ch] = cnt_reg[ch];
        end
    endgenerate

    assign count_start_irq = irq_reg;

endmodule

// ==== tsc_unit_properties.sv ====
`timescale 1ns/1ps

module tsc_unit_props
    import tsc_pkg::*;
#(
    parameter int CHANNELS = TSC_MAX_CHANNELS,
    parameter int UNIT = 0,
    parameter int COUNT_DIV = TSC_COUNT_DIV
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register access
    input wire tsc_bus_req_type bus_req,
    input wire logic [15:0] rdata,
    // Channel setup
    input wire tsc_chan_cfg_type [CHANNELS-1:0] channel_mode_config,
    input wire logic [CHANNELS-1:0][15:0] reload_data,
    input wire logic [CHANNELS-1:0] ext_start_trig,
    // Channel state
    input wire logic [CHANNELS-1:0] chan_enable_status,
    input wire logic [CHANNELS-1:0][15:0] channel_counter,
    input wire logic [CHANNELS-1:0] count_start_irq
);
    localparam logic [19:0] START_A = (UNIT == 0) ? TSC_START_OFS_U0 :
        ((UNIT == 1) ? TSC_START_OFS_U1 : TSC_START_OFS_U2);
    localparam logic [19:0] STOP_A = (UNIT == 0) ? TSC_STOP_OFS_U0 :
        ((UNIT == 1) ? TSC_STOP_OFS_U1 : TSC_STOP_OFS_U2);
    wire word_or_byte = bus_req.size != TSC_SIZE_BIT;
    wire start_wr = bus_req.wr && bus_req.addr == START_A && word_or_byte && bus_req.wdata[0];
    wire stop_wr = bus_req.wr && bus_req.addr == STOP_A && word_or_byte && bus_req.wdata[0];
    wire start_rd = bus_req.rd && bus_req.addr == START_A;
    wire stop_rd = bus_req.rd && bus_req.addr == STOP_A;
    tsc_mode_type mode0;
    wire cap_like = mode0 == TSC_MODE_CAPTURE || mode0 == TSC_MODE_CAP_ONE;
    assign mode0 = channel_mode_config[0].mode_select_field;

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_start_sets_enable: assert property (start_wr |-> ##2 chan_enable_status[0])
        else $error("start write did not enable channel 0");
    a_stop_clears_enable: assert property (stop_wr |-> ##2 !chan_enable_status[0])
        else $error("stop write did not disable channel 0");
    a_start_reads_zero: assert property (start_rd |=> rdata == 16'h0000)
        else $error("start register read nonzero");
    a_stop_reads_zero: assert property (stop_rd |=> rdata == 16'h0000)
        else $error("stop register read nonzero");
    a_stopped_counter_holds: assert property (
        !chan_enable_status[0] ##1 !chan_enable_status[0] |-> $stable(channel_counter[0]))
        else $error("counter moved while channel stopped");
    a_event_loads_now: assert property (
        mode0 == TSC_MODE_EVENT && $rose(chan_enable_status[0])
        |-> channel_counter[0] == reload_data[0])
        else $error("event mode did not load reload value on enable");
    a_wait_holds_counter: assert property (mode0 != TSC_MODE_EVENT
        && $rose(chan_enable_status[0]) |-> $stable(channel_counter[0]))
        else $error("counter changed at enable before count clock");
    a_start_load_value: assert property (count_start_irq[0]
        |-> channel_counter[0] == (cap_like ? TSC_CAPTURE_LOAD : reload_data[0]))
        else $error("wrong counter value at count start");
    a_irq_needs_select: assert property (count_start_irq[0]
        |-> channel_mode_config[0].start_irq_select && chan_enable_status[0])
        else $error("start interrupt without selection");
endmodule

bind tsc_unit tsc_unit_props #(.CHANNELS(CHANNELS), .UNIT(UNIT), .COUNT_DIV(COUNT_DIV)) u_props (
    .mclk(mclk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
    .channel_mode_config(channel_mode_config), .reload_data(reload_data),
    .ext_start_trig(ext_start_trig), .chan_enable_status(chan_enable_status),
    .channel_counter(channel_counter), .count_start_irq(count_start_irq)
);

// ==== tsc_unit_tb_top.sv ====
`timescale 1ns/1ps

module tsc_unit_tb_top;
    import tsc_pkg::*;
    localparam int DIV = 4;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    tsc_bus_req_type bus_req = '0;
    tsc_chan_cfg_type [7:0] cfg = '0;
    logic [7:0][15:0] reload = '0;
    logic [7:0] ext_trig = '0;
    logic [15:0] rdata;
    logic [7:0] en;
    logic [7:0][15:0] cnt;
    logic [7:0] irq;
    logic [31:0] seed_reg = 32'h0000_1573;
    int fail_count = 0;
    int compares = 0;
    tsc_mode_type modes [5] = '{TSC_MODE_INTERVAL, TSC_MODE_CAPTURE, TSC_MODE_EVENT,
        TSC_MODE_ONE_COUNT, TSC_MODE_CAP_ONE};

    tsc_unit #(.CHANNELS(8), .UNIT(0), .COUNT_DIV(DIV)) dut (
        .mclk(mclk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
        .channel_mode_config(cfg), .reload_data(reload), .ext_start_trig(ext_trig),
        .chan_enable_status(en), .channel_counter(cnt), .count_start_irq(irq)
    );

    always #10 mclk = ~mclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic cap_mode(input tsc_mode_type m);
        return m == TSC_MODE_CAPTURE || m == TSC_MODE_CAP_ONE;
    endfunction

    function automatic logic [15:0] exp_load(input tsc_mode_type m, input logic [15:0] r);
        return cap_mode(m) ? TSC_CAPTURE_LOAD : r;
    endfunction

    function automatic logic [15:0] exp_step(input tsc_mode_type m, input logic [15:0] v);
        return cap_mode(m) ? v + 16'h0001 : v - 16'h0001;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares = compares + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic bus_wr(input logic [19:0] a, input tsc_size_type s, input logic [15:0] d,
        input logic [2:0] b);
        @(posedge mclk);
        bus_req <= '{1'b1, 1'b0, s, a, d, b};
        @(posedge mclk);
        bus_req <= '0;
    endtask

    task automatic bus_rd(input logic [19:0] a, input logic [15:0] exp);
        @(posedge mclk);
        bus_req <= '{1'b0, 1'b1, TSC_SIZE_WORD, a, 16'h0000, 3'h0};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
        #1;
        check(rdata, exp);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic pulse(input int ch);
        @(posedge mclk);
        ext_trig[ch] <= 1'b1;
        @(posedge mclk);
        ext_trig[ch] <= 1'b0;
    endtask

    // Bounded waits; running out counts as a mismatch in wait_irq, wait_move just returns
    task automatic wait_irq(input int ch, output int lat);
        lat = 0;
        while (irq[ch] !== 1'b1 && lat < 8 * DIV)
        begin
            cycles(1);
            lat++;
        end
        check({15'h0000, irq[ch]}, 16'h0001);
    endtask

    task automatic wait_move(input int ch, input logic [15:0] old);
        int n;
        n = 0;
        while (cnt[ch] === old && n < 4 * DIV)
        begin
            cycles(1);
            n++;
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count = fail_count + 1;
        stop_test;
    end

    initial
    begin
        int ch;
        int lat;
        logic [15:0] held;
        logic [7:0] bitm;
        tsc_mode_type m;
        tsc_size_type sz;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        bus_rd(TSC_START_OFS_U0, TSC_TRIG_RESET);
        bus_rd(TSC_STOP_OFS_U0, TSC_TRIG_RESET);
        bus_rd(TSC_ENABLE_OFS_U0, TSC_ENABLE_RESET);
        bus_rd(20'h0_F01A0, 16'h0000);
        for (int pass = 0; pass < 2; pass++)
        for (int i = 0; i < 5; i++)
        begin
            seed_reg = xs(seed_reg);
            ch = (pass == 0) ? 0 : int'(seed_reg[18:16] | 3'h1);
            m = modes[i];
            bitm = 8'h01 << ch;
            @(posedge mclk);
            cfg[ch] <= '{m, 1'b1, (m == TSC_MODE_ONE_COUNT || m == TSC_MODE_EVENT) ?
                TSC_SRC_PIN : TSC_SRC_SOFTWARE};
            reload[ch] <= seed_reg[15:0] | 16'h0010;
            cycles(1);
            held = cnt[ch];
            if (m == TSC_MODE_EVENT)
            begin
                pulse(ch);
                cycles(2 * DIV);
                check({15'h0000, en[ch]}, 16'h0000);
                check(cnt[ch], held);
            end
            bus_wr(TSC_START_OFS_U0, TSC_SIZE_WORD, {8'h00, bitm}, 3'h0);
            // Look right after enable rises, before any count clock can load the counter
            cycles(1);
            check({15'h0000, en[ch]}, 16'h0001);
            if (m == TSC_MODE_EVENT)
            begin
                check(cnt[ch], reload[ch]);
                wait_move(ch, reload[ch]);
                check(cnt[ch], reload[ch] - 16'h0001);
            end
            else
            begin
                check(cnt[ch], held);
                if (m[2])
                begin
                    cycles(3 * DIV);
                    check(cnt[ch], held);
                    pulse(ch);
                end
                wait_irq(ch, lat);
                if (m == TSC_MODE_ONE_COUNT)
                    check({15'h0000, lat > DIV}, 16'h0001);
                if (m == TSC_MODE_CAP_ONE)
                    check({15'h0000, lat <= DIV + 1}, 16'h0001);
                check(cnt[ch], exp_load(m, reload[ch]));
                held = cnt[ch];
                wait_move(ch, held);
                check(cnt[ch], exp_step(m, held));
            end
            bus_rd(TSC_START_OFS_U0, 16'h0000);
            sz = tsc_size_type'(i % 3);
            bus_wr(TSC_STOP_OFS_U0, sz, (sz == TSC_SIZE_BIT) ? 16'h0001 : {8'h00, bitm},
                3'(ch));
            cycles(2);
            check({15'h0000, en[ch]}, 16'h0000);
            held = cnt[ch];
            cycles(3 * DIV);
            check(cnt[ch], held);
            bus_rd(TSC_STOP_OFS_U0, 16'h0000);
        end
        stop_test;
    end
endmodule
